// ===== core/scp_defines.svh
// constants for the serial configuration port
// Operation
// - on each serial-clock rise while select is low, shift data line into shift register
// - when select rises after a write frame, commit shift register data to the addressed register
// - first frame bit zero means write, one means read; device acts on it
// - during a read, readback output changes on serial-clock falling edge
// - four-wire readback output uses same edge timing as data-line readback
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH
`define SCP_ADDR_W     13
`define SCP_DATA_W     8
`define SCP_FRAME_W    24
`define SCP_DIR_BIT    23
`define SCP_WL_HI_BIT  22
`define SCP_WL_LO_BIT  21
`define SCP_ADDR_MSB   20
`define SCP_ADDR_LSB   8
`define SCP_REG_RST    8'h00
`endif

// ===== core/scp_pkg.sv
// types shared by the serial configuration port
package scp_pkg;
  // one decoded frame header plus data
  typedef struct packed {
    logic        rd;
    logic        word_len_hi;
    logic        word_len_lo;
    logic [12:0] addr;
    logic [7:0]  data;
  } scp_frame_t;

  // link pins after synchronisation
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic sdio;
  } scp_pins_t;
endpackage : scp_pkg

// ===== core/scp_sync.sv
// two-stage synchroniser for the link pins
`timescale 1ns/100ps
module scp_sync
  import scp_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      sys_rst_i,
  input  wire scp_pins_t pins_i,
  output scp_pins_t      pins_o
);
  scp_pins_t meta;
  scp_pins_t stage2;

  // first stage feeds only the second; idle level is select high
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta   <= '{sck: 1'b0, cs_n: 1'b1, sdio: 1'b0};
      stage2 <= '{sck: 1'b0, cs_n: 1'b1, sdio: 1'b0};
    end else begin
      meta   <= pins_i;
      stage2 <= meta;
    end
  end

  assign pins_o = stage2;
endmodule : scp_sync

// ===== core/scp_port.sv
// serial configuration port: shift, commit and readback logic
`timescale 1ns/100ps
`include "scp_defines.svh"
module scp_port
  import scp_pkg::*;
#(
  parameter int ADDR_W  = `SCP_ADDR_W,
  parameter int DATA_W  = `SCP_DATA_W,
  parameter int NUM_REG = 32
) (
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               sck_i,
  input  wire logic               cs_n_i,
  input  wire logic               sdio_i,
  output logic                    sdio_o,
  output logic                    sdio_oe_o,
  input  wire logic               four_wire_i,
  output logic                    rdbk_o,
  output logic                    wr_stb_o,
  output logic [ADDR_W-1:0]       wr_addr_o,
  output logic [DATA_W-1:0]       wr_data_o,
  output logic [NUM_REG*DATA_W-1:0] regs_o
);
  // ****************************************************************
  // input synchronisation and edge finding
  // ****************************************************************
  scp_pins_t pins_s;
  scp_pins_t pins_d;
  // the mode pin is strapped from outside, so it gets two flops as well
  logic      fw_meta;
  logic      fw_s;

  scp_sync u_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pins_i    ('{sck: sck_i, cs_n: cs_n_i, sdio: sdio_i}),
    .pins_o    (pins_s)
  );

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pins_d  <= '{sck: 1'b0, cs_n: 1'b1, sdio: 1'b0};
      fw_meta <= 1'b0;
      fw_s    <= 1'b0;
    end else begin
      pins_d  <= pins_s;
      fw_meta <= four_wire_i;
      fw_s    <= fw_meta;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  // sck at 320 ns gives four samples per half period at 25 MHz
  assign sck_rise = pins_s.sck & ~pins_d.sck;
  assign sck_fall = ~pins_s.sck & pins_d.sck;
  assign cs_rise  = pins_s.cs_n & ~pins_d.cs_n;

  // ****************************************************************
  // frame shifting
  // ****************************************************************
  typedef enum logic [2:0] {
    SCP_IDLE  = 3'b001,
    SCP_SHIFT = 3'b010,
    SCP_READ  = 3'b100
  } scp_state_t;

  scp_state_t                   state;
  scp_state_t                   next_state;
  logic [`SCP_FRAME_W-1:0]      shreg;
  logic [`SCP_FRAME_W-1:0]      next_shreg;
  logic [4:0]                   bitcnt;
  logic [4:0]                   next_bitcnt;
  logic [DATA_W-1:0]            rdsh;
  logic [DATA_W-1:0]            next_rdsh;
  logic                         rdbit;
  logic                         next_rdbit;
  logic [DATA_W-1:0]            regs [NUM_REG];

  localparam logic [4:0] HDR_BITS = 5'(`SCP_FRAME_W - DATA_W);

  // header fields decoded from a shifted word, msb first
  function automatic scp_frame_t scp_decode(input logic [`SCP_FRAME_W-1:0] w);
    scp_frame_t f;
    f.rd          = w[`SCP_DIR_BIT];
    f.word_len_hi = w[`SCP_WL_HI_BIT];
    f.word_len_lo = w[`SCP_WL_LO_BIT];
    f.addr        = w[`SCP_ADDR_MSB:`SCP_ADDR_LSB];
    f.data        = w[DATA_W-1:0];
    return f;
  endfunction : scp_decode

  // register lookup; addresses beyond the array read zero
  function automatic logic [DATA_W-1:0] scp_lookup(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_REG; i++) begin
      if (a == ADDR_W'(i)) begin
        v = regs[i];
      end
    end
    return v;
  endfunction : scp_lookup

  scp_frame_t hdr_now;
  // at the sixteenth rise only header bits are in; align them to the top of the word
  assign hdr_now = scp_decode({shreg[`SCP_FRAME_W-DATA_W-2:0], pins_s.sdio, {DATA_W{1'b0}}});

  always_comb begin
    next_state  = state;
    next_shreg  = shreg;
    next_bitcnt = bitcnt;
    next_rdsh   = rdsh;
    next_rdbit  = rdbit;
    if (pins_s.cs_n) begin
      // select high ends any frame; a partial frame is still committed
      next_state  = SCP_IDLE;
      next_bitcnt = '0;
      next_rdbit  = 1'b0;
    end else begin
      case (state)
        SCP_IDLE: begin
          next_state = SCP_SHIFT;
        end
        SCP_SHIFT: begin
          if (sck_rise) begin
            next_shreg  = {shreg[`SCP_FRAME_W-2:0], pins_s.sdio};
            next_bitcnt = bitcnt + 5'd1;
            if (bitcnt == HDR_BITS - 5'd1 && hdr_now.rd) begin
              next_state = SCP_READ;
              next_rdsh  = scp_lookup(hdr_now.addr[ADDR_W-1:0]);
            end
          end
        end
        SCP_READ: begin
          if (sck_rise) begin
            next_shreg  = {shreg[`SCP_FRAME_W-2:0], pins_s.sdio};
            next_bitcnt = bitcnt + 5'd1;
          end
          if (sck_fall) begin
            // data changes on falling edge so host samples on next rise
            next_rdbit = rdsh[DATA_W-1];
            next_rdsh  = {rdsh[DATA_W-2:0], 1'b0};
          end
        end
        default: begin
          next_state = SCP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state  <= SCP_IDLE;
      shreg  <= '0;
      bitcnt <= '0;
      rdsh   <= '0;
      rdbit  <= 1'b0;
    end else begin
      state  <= next_state;
      shreg  <= next_shreg;
      bitcnt <= next_bitcnt;
      rdsh   <= next_rdsh;
      rdbit  <= next_rdbit;
    end
  end

  // ****************************************************************
  // commit on select rise
  // ****************************************************************
  scp_frame_t         frame;
  logic               next_wr_stb;
  logic [ADDR_W-1:0]  next_wr_addr;
  logic [DATA_W-1:0]  next_wr_data;
  assign frame = scp_decode(shreg);

  // word-length bits are trusted to be zero and not checked
  always_comb begin
    next_wr_stb  = cs_rise & ~frame.rd;
    next_wr_addr = frame.addr[ADDR_W-1:0];
    next_wr_data = frame.data;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_stb_o  <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      for (int i = 0; i < NUM_REG; i++) begin
        regs[i] <= `SCP_REG_RST;
      end
    end else begin
      wr_stb_o <= next_wr_stb;
      if (next_wr_stb) begin
        wr_addr_o <= next_wr_addr;
        wr_data_o <= next_wr_data;
        for (int i = 0; i < NUM_REG; i++) begin
          if (next_wr_addr == ADDR_W'(i)) begin
            regs[i] <= next_wr_data;
          end
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_REG; i++) begin
      regs_o[i*DATA_W +: DATA_W] = regs[i];
    end
  end

  // ****************************************************************
  // readback drivers
  // ****************************************************************
  logic rd_drive;
  assign rd_drive = (state == SCP_READ) & ~pins_s.cs_n;

  // both outputs share one registered bit, so their timing matches
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sdio_o    <= 1'b0;
      sdio_oe_o <= 1'b0;
      rdbk_o    <= 1'b0;
    end else begin
      sdio_o    <= next_rdbit;
      sdio_oe_o <= rd_drive & ~fw_s & ~cs_rise;
      rdbk_o    <= fw_s ? next_rdbit : 1'b0;
    end
  end
endmodule : scp_port

// ===== dv/scp_port_props.sv
// checker for the serial configuration port outputs
`timescale 1ns/100ps
module scp_port_props
  import scp_pkg::*;
#(
  parameter int ADDR_W  = 13,
  parameter int DATA_W  = 8,
  parameter int NUM_REG = 32
) (
  input wire logic                      mclk_i,
  input wire logic                      sys_rst_i,
  input wire logic                      sck_i,
  input wire logic                      cs_n_i,
  input wire logic                      sdio_i,
  input wire logic                      sdio_o,
  input wire logic                      sdio_oe_o,
  input wire logic                      four_wire_i,
  input wire logic                      rdbk_o,
  input wire logic                      wr_stb_o,
  input wire logic [ADDR_W-1:0]         wr_addr_o,
  input wire logic [DATA_W-1:0]         wr_data_o,
  input wire logic [NUM_REG*DATA_W-1:0] regs_o
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // select held high long enough for the synchroniser to see it
  sequence idle_s;
    cs_n_i [*6];
  endsequence
  stb_pulse_a: assert property (wr_stb_o |=> !wr_stb_o)
    else $error("strobe wider than one cycle");
  stb_cause_a: assert property (wr_stb_o
    |-> cs_n_i && $past(cs_n_i, 3) && !$past(cs_n_i, 4))
    else $error("strobe without select rise");
  reg_commit_a: assert property (wr_stb_o && wr_addr_o < NUM_REG
    |-> regs_o[wr_addr_o*DATA_W +: DATA_W] == wr_data_o) else $error("register not committed");
  oe_idle_a: assert property (idle_s |-> !sdio_oe_o)
    else $error("data line driven while deselected");
  oe_mode_a: assert property (sdio_oe_o |-> !four_wire_i)
    else $error("data line driven in four-wire mode");
  rdbk_mode_a: assert property (rdbk_o |-> four_wire_i)
    else $error("readback output active in three-wire mode");
  sdio_fall_a: assert property ($changed(sdio_o) |-> !sck_i && !$past(sck_i, 2))
    else $error("readback changed away from falling edge");
  rdbk_fall_a: assert property ($changed(rdbk_o) |-> !sck_i && !$past(sck_i, 2))
    else $error("four-wire readback changed away from falling edge");
endmodule : scp_port_props

// ===== dv/scp_host.sv
// host controller model driving the serial configuration port
`timescale 1ns/100ps
module scp_host (
  input  wire logic mclk_i,
  input  wire logic rd_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      sdo_o
);
  // ****
  // link driver
  // ****
  // link clock stands low and select high outside frames
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdo_o = 1'b1;
  end
  // half link period is four system cycles, skewed off the edge
  task automatic half();
    repeat (4) @(posedge mclk_i);
    #1;
  endtask : half
  // one frame msb first; released data bits toggle so stale values never pass
  task automatic xfer(input logic [23:0] f, output logic [7:0] rd);
    half();
    cs_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdo_o = (f[23] && i < 8) ? ~sdo_o : f[i];
      half();
      sck_o = 1'b1;
      rd = {rd[6:0], rd_i};
      half();
      sck_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    sdo_o = ~sdo_o;
  endtask : xfer
endmodule : scp_host

// ===== dv/scp_port_test.sv
// self-checking bench for the serial configuration port
`timescale 1ns/100ps
module scp_port_test;
  import scp_pkg::*;
  logic         mclk_i = 1'b0;
  logic         sys_rst_i = 1'b1;
  logic         four_wire = 1'b0;
  logic         sck, cs_n, sdo, sdio_o, sdio_oe_o, rdbk_o, wr_stb_o;
  logic [12:0]  wr_addr_o;
  logic [7:0]   wr_data_o, rd;
  logic [255:0] regs_o;
  int           bad_count = 0;
  int           comparisons = 0;
  int           stbs = 0;
  int           oes = 0;
  wire          line = sdio_oe_o ? sdio_o : sdo;
  always #20 mclk_i = ~mclk_i;
  // ****
  // monitors and helpers
  // ****
  always @(posedge mclk_i) begin
    stbs += int'(wr_stb_o === 1'b1);
    oes += int'(sdio_oe_o === 1'b1);
  end
  scp_port i_scp_port (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sck_i(sck), .cs_n_i(cs_n),
    .sdio_i(line), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .four_wire_i(four_wire),
    .rdbk_o(rdbk_o), .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .regs_o(regs_o));
  scp_host i_scp_host (.mclk_i(mclk_i), .rd_i(four_wire ? rdbk_o : line), .sck_o(sck),
    .cs_n_o(cs_n), .sdo_o(sdo));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // bounded wait, so a missing strobe ends the run instead of hanging it
  task automatic wait_stb();
    int i;
    for (i = 0; i < 20 && wr_stb_o !== 1'b1; i++) @(posedge mclk_i) #2;
    if (i == 20) begin
      bad_count++;
      $display("unexpected write strobe expected 1 seen 0");
      print_verdict();
    end
  endtask : wait_stb
  task automatic t_write(input logic [12:0] a, input logic [7:0] d);
    i_scp_host.xfer({3'b000, a, d}, rd);
    wait_stb();
    chk("commit address", 24'(a), 24'(wr_addr_o));
    chk("commit data", 24'(d), 24'(wr_data_o));
    chk("register", 24'(d), 24'(regs_o[a*8 +: 8]));
    $display("write test done");
  endtask : t_write
  task automatic t_read(input logic [12:0] a, input logic [7:0] d, input logic fw);
    int s;
    int o;
    @(posedge mclk_i) #1 four_wire = fw;
    s = stbs;
    o = oes;
    i_scp_host.xfer({3'b100, a, 8'h00}, rd);
    repeat (10) @(posedge mclk_i);
    chk("read data", 24'(d), 24'(rd));
    chk("read strobes", 24'h0, 24'(stbs - s));
    chk("line driven", 24'(!fw), 24'(oes > o));
    chk("register kept", 24'(d), 24'(regs_o[a*8 +: 8]));
    $display("read test done");
  endtask : t_read
  initial begin
    repeat (8) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #2;
    chk("reset registers", 24'h0, 24'(regs_o != '0));
    t_write(13'h0005, 8'hA5);
    t_write(13'h001F, 8'h3C);
    t_read(13'h0005, 8'hA5, 1'b0);
    t_read(13'h001F, 8'h3C, 1'b1);
    print_verdict();
  end
endmodule : scp_port_test
bind scp_port scp_port_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .NUM_REG(NUM_REG))
  i_scp_port_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
  .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .four_wire_i(four_wire_i),
  .rdbk_o(rdbk_o), .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
  .regs_o(regs_o));
